/* verilog/pcde_pkg.sv */
`default_nettype none
package pcde_pkg;
  // System clock period
  localparam int CLK_NS          = 20;
  // Overcurrent debounce time, typical figure inside the allowed window
  localparam int DEB_NS          = 3500;
  // Least time, rounded up to whole cycles
  localparam int DEB_CYC         = (DEB_NS + CLK_NS - 1) / CLK_NS;
  // Low time on the duty line that clears the latch
  localparam int CLR_NS          = 500;
  // Device side: longest time, rounded down
  localparam int CLR_CYC         = CLR_NS / CLK_NS;
  // Controller side: least time rounded up, plus margin
  localparam int CLR_HOLD_CYC    = (CLR_NS + CLK_NS - 1) / CLK_NS + 2;
  // Duty ratio in parts per million
  localparam int PPM_FULL        = 1000000;
  localparam int DUTY_ZERO_PPM   = 200000;
  localparam int DUTY_MIN_PPM    = 100000;
  localparam int DUTY_MAX_PPM    = 300000;
  // Gain: 40 percent per volt is 400 ppm per millivolt
  localparam int GAIN_PPM_PER_MV = 400;
  // Decoded duty is reported in permille
  localparam int PM_FULL         = 1000;
  // Default sync half period in cycles (10 kHz sync)
  localparam int SYNC_HALF_CYC   = 2500;
  // Overcurrent latch states
  typedef enum logic [2:0] {
    PCDE_OC_WATCH = 3'h1,
    PCDE_OC_FLAG  = 3'h2,
    PCDE_OC_HOLD  = 3'h4
  } pcde_oc_state_t;
endpackage
`default_nettype wire

/* verilog/pcde_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Link between sensor and controller: sync line and two open-drain lines
interface pcde_if;
  logic sync;                 // Sync, driven by controller
  logic dev_duty_o;           // Device duty pin data (always low)
  logic dev_duty_oe_n;        // Low while device pulls duty line
  logic dev_flag_o;           // Device flag pin data (always low)
  logic dev_flag_oe_n;        // Low while device pulls flag line
  logic ctl_duty_o;           // Controller duty pin data
  logic ctl_duty_oe_n;        // Low while controller pulls duty line
  logic tie_flag_to_duty;     // Board strap: flag pin shorted to duty pin
  logic duty_line;            // Resolved duty line, pulled up
  logic flag_line;            // Resolved flag line, pulled up
  logic dev_pull;
  logic flag_pull;
  logic ctl_pull;
  // Wired-AND with pull-ups; the strap joins the two nets
  assign dev_pull  = ~dev_duty_oe_n & ~dev_duty_o;
  assign flag_pull = ~dev_flag_oe_n & ~dev_flag_o;
  assign ctl_pull  = ~ctl_duty_oe_n & ~ctl_duty_o;
  assign duty_line = ~(dev_pull | ctl_pull | (tie_flag_to_duty & flag_pull));
  assign flag_line = ~(flag_pull | (tie_flag_to_duty & (dev_pull | ctl_pull)));
  modport dev (input sync, input duty_line, input flag_line,
               output dev_duty_o, output dev_duty_oe_n, output dev_flag_o, output dev_flag_oe_n);
  modport ctl (output sync, output ctl_duty_o, output ctl_duty_oe_n,
               input duty_line, input flag_line);
endinterface
`default_nettype wire

/* verilog/pcde_edge_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Splits a level into segments and counts cycles inside the current one
module pcde_edge_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             level,
  output logic                  edge_p,
  output logic                  level_q,
  output logic [CNT_W-1:0]      cnt_q,
  output logic [CNT_W-1:0]      cnt_d
);
  logic level_d;

  // Next values; the counter saturates rather than wrapping on a stuck level
  always_comb begin
    edge_p  = (level != level_q);
    level_d = level;
    if (edge_p) begin
      cnt_d = '0;
    end else if (&cnt_q) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  // Registers, frozen while clock enable is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'h0;
      cnt_q   <= '0;
    end else if (ce) begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/pcde_device.sv */
`timescale 1ns/10ps
`default_nettype none
module pcde_device #(
  parameter int CNT_W = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  pcde_if.dev                     link,
  input  wire logic signed [15:0] vin_mv,
  input  wire logic [15:0]        oc_threshold_mv,
  output logic                    oc_latched
);
  // Debounce counter width follows the cycle count
  localparam int DEB_W = $clog2(pcde_pkg::DEB_CYC + 1);
  localparam int CLR_W = $clog2(pcde_pkg::CLR_CYC + 1);

  logic             sync_edge;   // Sync changed this cycle
  logic             sync_q;      // Sync level of the cycle now running
  logic [CNT_W-1:0] pos_q;       // Position inside the current cycle
  logic [CNT_W-1:0] pos_d;       // Position next cycle

  logic             primed_q;    // One edge seen, next cycle is full
  logic             primed_d;
  logic             valid_q;     // A duty value is being sent
  logic             valid_d;
  logic             chan_one_q;  // Cycle being sent carries channel one
  logic             chan_one_d;
  logic [CNT_W-1:0] high_q;      // Released cycles in the current cycle
  logic [CNT_W-1:0] high_d;
  logic             drive_q;     // Device pulls the duty line low
  logic             drive_d;

  pcde_pkg::pcde_oc_state_t oc_q;  // Overcurrent latch state
  pcde_pkg::pcde_oc_state_t oc_d;
  logic [DEB_W-1:0] deb_q;       // Cycles the overcurrent has lasted
  logic [DEB_W-1:0] deb_d;
  logic [CLR_W-1:0] clr_q;       // Cycles the duty line has been held low
  logic [CLR_W-1:0] clr_d;
  logic [16:0]      vin_mag;     // Magnitude of the differential input
  logic             oc_raw;      // Input over threshold right now
  logic             oc_met;      // Over threshold longer than debounce
  logic             clr_done;    // Low hold long enough to clear

  // Duty ratio in ppm for a given input, clamped to the legal band
  function automatic longint duty_ppm(input logic signed [15:0] mv);
    longint d;
    d = longint'(pcde_pkg::DUTY_ZERO_PPM) - longint'(pcde_pkg::GAIN_PPM_PER_MV) * longint'(mv);
    if (d < longint'(pcde_pkg::DUTY_MIN_PPM)) begin
      d = longint'(pcde_pkg::DUTY_MIN_PPM);
    end else if (d > longint'(pcde_pkg::DUTY_MAX_PPM)) begin
      d = longint'(pcde_pkg::DUTY_MAX_PPM);
    end
    return d;
  endfunction

  // Released time for a cycle: duty of the sample times that cycle's period
  function automatic logic [CNT_W-1:0] high_cycles(input logic [CNT_W-1:0] per,
                                                    input logic signed [15:0] mv);
    longint h;
    h = longint'(per) * duty_ppm(mv) / longint'(pcde_pkg::PPM_FULL);
    return CNT_W'(h);
  endfunction

  // Sync drives every encoder timing decision; no free-running timer exists
  pcde_edge_timer #(
    .CNT_W (CNT_W)
  ) u_sync_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .level   (link.sync),
    .edge_p  (sync_edge),
    .level_q (sync_q),
    .cnt_q   (pos_q),
    .cnt_d   (pos_d)
  );

  // Overcurrent detect: magnitude against the threshold
  always_comb begin
    if (vin_mv < 16'sh0000) begin
      vin_mag = 17'h0_0000 - {vin_mv[15], vin_mv};
    end else begin
      vin_mag = {1'h0, vin_mv};
    end
    oc_raw = (vin_mag > {1'h0, oc_threshold_mv});
    oc_met = oc_raw && (deb_q == DEB_W'(pcde_pkg::DEB_CYC));
  end

  // Encoder next values
  always_comb begin
    primed_d   = primed_q;
    valid_d    = valid_q;
    chan_one_d = chan_one_q;
    high_d     = high_q;
    if (sync_edge) begin
      // The cycle just finished is sampled at its closing edge
      primed_d = 1'h1;
      if (primed_q) begin
        // The first segment after reset is partial, so it is never sent
        valid_d    = 1'h1;
        chan_one_d = sync_q;
        // Period of the finished cycle alone, so uneven sync halves decode right
        high_d     = high_cycles(pos_q + CNT_W'(1), vin_mv);
      end
    end
    // Release first, then pull low for the rest of the cycle
    drive_d = valid_d && (pos_d >= high_d) && (oc_d != pcde_pkg::PCDE_OC_FLAG);
  end

  // Encoder registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_q   <= 1'h0;
      valid_q    <= 1'h0;
      chan_one_q <= 1'h0;
      high_q     <= '0;
      drive_q    <= 1'h0;
    end else if (ce) begin
      primed_q   <= primed_d;
      valid_q    <= valid_d;
      chan_one_q <= chan_one_d;
      high_q     <= high_d;
      drive_q    <= drive_d;
    end
  end

  // Overcurrent latch next values
  always_comb begin
    oc_d     = oc_q;
    deb_d    = deb_q;
    clr_d    = '0;
    clr_done = 1'h0;
    // Debounce counter restarts whenever the input drops under threshold
    if (!oc_raw) begin
      deb_d = '0;
    end else if (deb_q != DEB_W'(pcde_pkg::DEB_CYC)) begin
      deb_d = deb_q + DEB_W'(1);
    end
    // Low levels count unless our own duty pull makes them, so our flag pull through the strap counts too
    if ((oc_q == pcde_pkg::PCDE_OC_FLAG) && !drive_q && !link.duty_line) begin
      if (clr_q == CLR_W'(pcde_pkg::CLR_CYC - 1)) begin
        clr_done = 1'h1;
      end else begin
        clr_d = clr_q + CLR_W'(1);
      end
    end
    case (oc_q)
      pcde_pkg::PCDE_OC_WATCH: begin
        if (oc_met) begin
          oc_d = pcde_pkg::PCDE_OC_FLAG;
        end
      end
      pcde_pkg::PCDE_OC_FLAG: begin
        // With the strap, our own flag holds the line low and clears itself
        if (clr_done) begin
          oc_d = pcde_pkg::PCDE_OC_HOLD;
        end
      end
      pcde_pkg::PCDE_OC_HOLD: begin
        // After a clear, a lasting fault may only come back on a sync edge
        if (sync_edge && oc_met) begin
          oc_d = pcde_pkg::PCDE_OC_FLAG;
        end else if (sync_edge || !oc_raw) begin
          oc_d = pcde_pkg::PCDE_OC_WATCH;
        end
      end
      default: begin
        oc_d = pcde_pkg::PCDE_OC_WATCH;
      end
    endcase
  end

  // Overcurrent latch registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_q  <= pcde_pkg::PCDE_OC_WATCH;
      deb_q <= '0;
      clr_q <= '0;
    end else if (ce) begin
      oc_q  <= oc_d;
      deb_q <= deb_d;
      clr_q <= clr_d;
    end
  end

  // Pins only ever pull low; the high level is the external pull-up
  assign link.dev_duty_o    = 1'h0;
  assign link.dev_duty_oe_n = ~drive_q;
  assign link.dev_flag_o    = 1'h0;
  assign link.dev_flag_oe_n = ~(oc_q == pcde_pkg::PCDE_OC_FLAG);
  assign oc_latched         = (oc_q == pcde_pkg::PCDE_OC_FLAG);
endmodule
`default_nettype wire

/* verilog/pcde_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Controller end: makes sync from a carrier, decodes duty, clears overcurrent
module pcde_ctrl #(
  parameter int HALF_CYC = pcde_pkg::SYNC_HALF_CYC,
  parameter int CNT_W    = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  pcde_if.ctl                     link,
  input  wire logic               quad_mode,
  input  wire logic               clear_req,
  input  wire logic signed [15:0] offset_ch1_pm,
  input  wire logic signed [15:0] offset_ch2_pm,
  output logic signed [15:0]      sample_pm_q,
  output logic                    sample_chan_one_q,
  output logic                    sample_valid_q,
  output logic signed [15:0]      avg_pm_q,
  output logic                    oc_flag_q
);
  localparam int CLR_W = $clog2(pcde_pkg::CLR_HOLD_CYC + 1);

  logic [CNT_W:0]   car_q, car_d;       // Carrier phase, one full sync period
  logic [CNT_W:0]   ph;                 // Phase used for sync
  logic             sync_q, sync_d;     // Sync driven out
  logic             syncp_q;            // Sync one cycle later
  logic             edge_c;             // Cycle boundary seen
  logic [CNT_W-1:0] per_q, per_d;       // Length of running cycle
  logic [CNT_W-1:0] hi_q, hi_d;         // Released time in running cycle
  logic [CNT_W-1:0] pper_q, pper_d;     // Period of previous cycle
  logic             pchan_q, pchan_d;   // Channel of previous cycle
  logic [1:0]       seen_q, seen_d;     // Boundaries seen, saturating
  logic signed [15:0] smp_d, avg_d;
  logic             sval_d, schan_d;
  logic [CLR_W-1:0] clr_q, clr_d;       // Remaining low-hold cycles
  logic             pull_q, pull_d;     // Controller pulls duty line low
  logic signed [16:0] corr;

  // Restoring divider, used for the duty ratio
  function automatic logic [15:0] div_u(input logic [31:0] num, input logic [CNT_W-1:0] den);
    logic [32:0] r;
    logic [31:0] q;
    r = '0;
    q = '0;
    if (den == '0) begin
      return 16'h0000;
    end
    for (int i = 31; i >= 0; i--) begin
      r = {r[31:0], num[i]};
      if (r >= 33'(den)) begin
        r    = r - 33'(den);
        q[i] = 1'h1;
      end
    end
    return q[15:0];
  endfunction

  // Carrier, sync generation, decoding and clear hold
  always_comb begin
    car_d = (car_q == (CNT_W+1)'(2 * HALF_CYC - 1)) ? '0 : car_q + (CNT_W+1)'(1);
    // Optional quarter-period shift for odd-harmonic cancellation
    ph = car_d;
    if (quad_mode) begin
      ph = car_d + (CNT_W+1)'(HALF_CYC / 2);
      if (ph >= (CNT_W+1)'(2 * HALF_CYC)) begin
        ph = ph - (CNT_W+1)'(2 * HALF_CYC);
      end
    end
    sync_d  = (ph < (CNT_W+1)'(HALF_CYC));
    edge_c  = (sync_q != syncp_q);
    per_d   = edge_c ? CNT_W'(1) : per_q + CNT_W'(1);
    hi_d    = edge_c ? CNT_W'(link.duty_line) : hi_q + CNT_W'(link.duty_line);
    pper_d  = pper_q;
    pchan_d = pchan_q;
    seen_d  = seen_q;
    smp_d   = sample_pm_q;
    avg_d   = avg_pm_q;
    schan_d = sample_chan_one_q;
    sval_d  = 1'h0;
    corr    = '0;
    if (edge_c) begin
      pper_d  = per_q;
      pchan_d = syncp_q;
      seen_d  = (seen_q == 2'h3) ? seen_q : seen_q + 2'h1;
      if (seen_q >= 2'h2) begin
        // Released time now over the previous cycle's period
        corr    = 17'(signed'({1'h0, div_u(32'(hi_q) * 32'(pcde_pkg::PM_FULL), pper_q)}));
        corr    = corr - 17'(pchan_q ? offset_ch1_pm : offset_ch2_pm);
        smp_d   = corr[15:0];
        schan_d = pchan_q;
        sval_d  = 1'h1;
        avg_d   = 16'((corr + 17'(sample_pm_q)) >>> 1);
      end
    end
    // Clear request holds the duty line low long enough
    clr_d = clr_q;
    if (clr_q != '0) begin
      clr_d = clr_q - CLR_W'(1);
    end else if (clear_req) begin
      clr_d = CLR_W'(pcde_pkg::CLR_HOLD_CYC);
    end
    pull_d = (clr_d != '0);
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      car_q             <= '0;
      sync_q            <= 1'h0;
      syncp_q           <= 1'h0;
      per_q             <= '0;
      hi_q              <= '0;
      pper_q            <= '0;
      pchan_q           <= 1'h0;
      seen_q            <= 2'h0;
      sample_pm_q       <= 16'sh0000;
      avg_pm_q          <= 16'sh0000;
      sample_chan_one_q <= 1'h0;
      sample_valid_q    <= 1'h0;
      clr_q             <= '0;
      pull_q            <= 1'h0;
      oc_flag_q         <= 1'h0;
    end else if (ce) begin
      car_q             <= car_d;
      sync_q            <= sync_d;
      syncp_q           <= sync_q;
      per_q             <= per_d;
      hi_q              <= hi_d;
      pper_q            <= pper_d;
      pchan_q           <= pchan_d;
      seen_q            <= seen_d;
      sample_pm_q       <= smp_d;
      avg_pm_q          <= avg_d;
      sample_chan_one_q <= schan_d;
      sample_valid_q    <= sval_d;
      clr_q             <= clr_d;
      pull_q            <= pull_d;
      oc_flag_q         <= ~link.flag_line;
    end
  end

  assign link.sync          = sync_q;
  assign link.ctl_duty_o    = 1'h0;
  assign link.ctl_duty_oe_n = ~pull_q;
endmodule
`default_nettype wire

/* tb/pcde_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// Link checker: sees only the shared wires between sensor and controller
module pcde_link_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sync,
  input wire logic dev_duty_o,
  input wire logic dev_duty_oe_n,
  input wire logic dev_flag_o,
  input wire logic dev_flag_oe_n,
  input wire logic ctl_duty_oe_n,
  input wire logic duty_line
);
  logic sync_q, flag_oe_q, seen_q;     // Previous levels, first edge seen
  logic sync_d, flag_oe_d, seen_d;
  int   age_q, len_q, low_q, ctl_q, rel_q; // Cycle counters
  int   age_d, len_d, low_d, ctl_d, rel_d;
  int   lo, hi;                        // Allowed duty fall window
  // Age, low and release counters saturate so a long quiet run cannot wrap
  always_comb begin
    sync_d    = sync;
    flag_oe_d = dev_flag_oe_n;
    seen_d    = seen_q | (sync != sync_q);
    age_d     = (sync != sync_q) ? 0 : ((age_q < 9999) ? age_q + 1 : age_q);
    len_d     = (sync != sync_q) ? (seen_q ? age_q + 1 : 0) : len_q;
    low_d     = (!duty_line && dev_duty_oe_n) ? ((low_q < 9999) ? low_q + 1 : low_q) : 0;
    ctl_d     = (!ctl_duty_oe_n && ctl_q < 9999) ? ctl_q + 1 : 0;
    rel_d     = (dev_flag_oe_n && !flag_oe_q) ? 0 : ((rel_q < 9999) ? rel_q + 1 : rel_q);
    lo        = len_q / 10;
    hi        = len_q * 3 / 10 + 2;
  end
  // Registers only; the first half after reset has no known length
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q    <= 1'b0;
      flag_oe_q <= 1'b1;
      seen_q    <= 1'b0;
      age_q     <= 0;
      len_q     <= 0;
      low_q     <= 0;
      ctl_q     <= 0;
      rel_q     <= 9999;
    end else begin
      sync_q    <= sync_d;
      flag_oe_q <= flag_oe_d;
      seen_q    <= seen_d;
      age_q     <= age_d;
      len_q     <= len_d;
      low_q     <= low_d;
      ctl_q     <= ctl_d;
      rel_q     <= rel_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sync_edge;
    $changed(sync);
  endsequence
  sequence s_flag_release;
    $rose(dev_flag_oe_n);
  endsequence
  a_duty_pull_only:
    assert property (dev_duty_o == 1'b0) else $error("duty pin data not low");
  a_flag_pull_only:
    assert property (dev_flag_o == 1'b0) else $error("flag pin data not low");
  a_fault_frees_duty:
    assert property (!dev_flag_oe_n && !$past(dev_flag_oe_n) |-> dev_duty_oe_n) else $error("duty pulled in fault");
  a_edge_frees_duty:
    assert property (s_sync_edge |-> ##[1:2] dev_duty_oe_n) else $error("duty not released after sync edge");
  a_duty_fall_window:
    assert property ($fell(dev_duty_oe_n) && len_q > 0 && rel_q > 200 |-> age_q >= lo && age_q <= hi)
      else $error("released time outside duty range");
  a_duty_low_span:
    assert property ($fell(dev_duty_oe_n) |-> (!dev_duty_oe_n || !dev_flag_oe_n)[*8]) else $error("short pull");
  a_clear_needs_hold:
    assert property (s_flag_release |-> low_q >= pcde_pkg::CLR_CYC - 1) else $error("flag cleared without hold");
  a_clear_within_bound:
    assert property (low_q == 27 |-> dev_flag_oe_n) else $error("flag kept after clear hold");
  a_reassert_at_edge:
    assert property ($fell(dev_flag_oe_n) && rel_q < 150 |-> age_q <= 3) else $error("reassert off sync edge");
  a_ctl_hold_length:
    assert property ($rose(ctl_duty_oe_n) |-> ctl_q >= pcde_pkg::CLR_CYC) else $error("clear hold too short");
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// Joins both ends over the link; judges decode, fault latch and clearing
module testbench;
  localparam int HALF = 100;                   // Short sync half keeps the run brief
  localparam int OFF1 = 5;                     // Channel one offset, permille
  localparam int OFF2 = -3;                    // Channel two offset, permille
  localparam int VIN [6] = '{0, 100, -250, 250, 300, -300};
  localparam int EXPD[6] = '{200, 160, 300, 100, 100, 300};
  logic               sys_clk   = 1'b0;
  logic               rst_n     = 1'b0;
  logic               ce        = 1'b1;        // Tied: freezing is not exercised
  logic signed [15:0] vin_mv    = 16'h0000;
  logic [15:0]        thr_mv    = 16'h03e8;    // 1000 mV keeps decode runs fault free
  logic               quad_mode = 1'b0;
  logic               clear_req = 1'b0;
  logic signed [15:0] off1      = 16'h0005;
  logic signed [15:0] off2      = 16'hfffd;
  logic               oc_latched, chan_one, valid, oc_flag;
  logic signed [15:0] sample_pm, avg_pm;
  wire logic          sync_w, duty_w, flag_w;  // Link levels seen by the bench
  int                 n_mismatch = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  pcde_if u_pcde_if ();
  assign sync_w = u_pcde_if.sync;
  assign duty_w = u_pcde_if.duty_line;
  assign flag_w = u_pcde_if.flag_line;
  pcde_device #(.CNT_W(16)) u_pcde_device (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .link(u_pcde_if),
    .vin_mv(vin_mv), .oc_threshold_mv(thr_mv), .oc_latched(oc_latched));
  pcde_ctrl #(.HALF_CYC(HALF), .CNT_W(16)) u_pcde_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .link(u_pcde_if), .quad_mode(quad_mode), .clear_req(clear_req), .offset_ch1_pm(off1),
    .offset_ch2_pm(off2), .sample_pm_q(sample_pm), .sample_chan_one_q(chan_one),
    .sample_valid_q(valid), .avg_pm_q(avg_pm), .oc_flag_q(oc_flag));
  pcde_link_assertions u_pcde_link_assertions (.sys_clk(sys_clk), .rst_n(rst_n), .sync(u_pcde_if.sync),
    .dev_duty_o(u_pcde_if.dev_duty_o), .dev_duty_oe_n(u_pcde_if.dev_duty_oe_n),
    .dev_flag_o(u_pcde_if.dev_flag_o), .dev_flag_oe_n(u_pcde_if.dev_flag_oe_n),
    .ctl_duty_oe_n(u_pcde_if.ctl_duty_oe_n), .duty_line(u_pcde_if.duty_line));
  always #10 sys_clk = ~sys_clk;
  // Hang guard: the whole run needs about 6000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the device's own flag pull; with the strap the line also follows duty pulls
  task automatic wait_flag(input logic lvl, output int k);
    k = 0;
    while (u_pcde_if.dev_flag_oe_n !== lvl && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task automatic wait_sync();
    logic s;
    int   k;
    s = sync_w;
    k = 0;
    while (sync_w === s && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task automatic next_sample();
    int k;
    k = 0;
    @(negedge sys_clk);
    while (valid !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    check(k < 2 * HALF, 1'b1);
  endtask
  // Clears just after a sync edge, so the hold never straddles the next one
  task automatic clear_after_edge(output int k);
    wait_sync();
    repeat (5) @(negedge sys_clk);
    clear_req = 1'b1;
    @(negedge sys_clk);
    clear_req = 1'b0;
    wait_flag(1'b1, k);
  endtask
  task automatic t_idle();
    check({duty_w, flag_w, valid}, 3'h6);
  endtask
  // Decoded value per channel, pair average and raw released time on the wire
  task automatic t_decode(input int i);
    int   hi;
    int   k;
    logic s;
    vin_mv    = 16'(VIN[i]);
    quad_mode = (i >= 4);
    repeat (4) next_sample();
    check(chan_one, sync_w);
    check(sample_pm, EXPD[i] - (chan_one ? OFF1 : OFF2));
    next_sample();
    check(sample_pm, EXPD[i] - (chan_one ? OFF1 : OFF2));
    check(avg_pm, EXPD[i] - 1);
    wait_sync();
    s  = sync_w;
    hi = 0;
    k  = 0;
    while (sync_w === s && k < 400) begin
      hi += int'(duty_w);
      @(negedge sys_clk);
      k++;
    end
    check(hi, EXPD[i] * HALF / 1000);
  endtask
  task automatic t_oc_short();
    int lows;
    lows   = 0;
    vin_mv = 16'h012c;                         // 300 mV, shorter than debounce
    repeat (100) @(negedge sys_clk);
    vin_mv = 16'h0000;
    repeat (300) begin
      @(negedge sys_clk);
      lows += int'(!flag_w);
    end
    check(lows, 0);
  endtask
  task automatic t_oc_latch();
    int k;
    int hi;
    int lows;
    vin_mv = 16'hfed4;                         // -300 mV: magnitude counts
    wait_flag(1'b0, k);
    check(k >= 135 && k <= 235, 1'b1);
    @(negedge sys_clk);
    check({oc_latched, oc_flag}, 2'h3);
    vin_mv = 16'h0000;
    hi     = 0;
    lows   = 0;
    repeat (300) begin
      @(negedge sys_clk);
      hi   += int'(duty_w);
      lows += int'(!flag_w);
    end
    check(hi, 300);
    check(lows, 300);
    clear_after_edge(k);
    check(k <= 32, 1'b1);
    repeat (3) @(negedge sys_clk);
    check(oc_latched, 1'b0);
  endtask
  task automatic t_oc_persist();
    int   k;
    int   lows;
    logic s;
    vin_mv = 16'h012c;                         // Held over threshold through the clear
    wait_flag(1'b0, k);
    clear_after_edge(k);
    lows = 0;
    k    = 0;
    s    = sync_w;
    // Exactly one sync edge may pass before the flag comes back
    while (flag_w === 1'b1 && k < 400) begin
      @(negedge sys_clk);
      lows += int'(sync_w !== s);
      s     = sync_w;
      k++;
    end
    check(k > HALF / 2 && k < HALF, 1'b1);
    check(lows, 1);
    vin_mv = 16'h0000;
    clear_after_edge(k);
  endtask
  task automatic t_auto();
    int k;
    u_pcde_if.tie_flag_to_duty = 1'b1;
    vin_mv = 16'h012c;
    wait_flag(1'b0, k);
    wait_flag(1'b1, k);
    check(k <= 30, 1'b1);
    wait_flag(1'b0, k);
    check(k <= HALF + 4, 1'b1);
    vin_mv = 16'h0000;
    repeat (2 * HALF) @(negedge sys_clk);
    check({u_pcde_if.dev_flag_oe_n, oc_latched}, 2'h2);
    u_pcde_if.tie_flag_to_duty = 1'b0;
  endtask
  initial begin
    u_pcde_if.tie_flag_to_duty = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_idle();
    for (int i = 0; i < 6; i++) begin
      t_decode(i);
    end
    thr_mv = 16'h00c8;                         // 200 mV threshold for the fault runs
    t_oc_short();
    t_oc_latch();
    t_oc_persist();
    t_auto();
    print_verdict();
  end
endmodule
`default_nettype wire
